// [hdl/mba_pkg.sv]
// Shared constants, modes and carriers for the host access block
`default_nettype none
package mba_pkg;

  // Sizes of the cell groups
  localparam int unsigned NCELL  = 16;
  localparam int unsigned NGRP   = 8;
  localparam int unsigned NIN    = 24;
  localparam int unsigned NSEL   = 8;
  localparam int unsigned INGRP  = 4;
  localparam int unsigned NINPT  = NIN / INGRP;

  // Word offsets inside the io control space (low address byte)
  localparam logic [7:0] OFS_IN_AB = 8'h18;
  localparam logic [7:0] OFS_IN_C  = 8'h1A;
  localparam logic [7:0] OFS_CELL  = 8'h20;
  localparam logic [7:0] OFS_MASK  = 8'h22;

  // Reset values
  localparam logic [7:0]  MASK_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  // Input cell modes, two bits per cell
  localparam logic [1:0] IM_PASS  = 2'h0;
  localparam logic [1:0] IM_LATCH = 2'h1;
  localparam logic [1:0] IM_REG   = 2'h2;

  // Write lane decode style
  typedef enum logic {
    WM_BYTE_EN = 1'b0,
    WM_SPLIT   = 1'b1
  } mba_wmode_e;

  // Host side pins, sampled on the core clock
  typedef struct packed {
    logic [15:0] ad;          // addr_data_port level
    logic [15:0] data;        // data ports in non-multiplexed mode
    logic        ctrl0_n;     // ctrl_pin_zero: write / low_byte_write
    logic        ctrl1_n;     // ctrl_pin_one: read strobe
    logic        ctrl2;       // ctrl_pin_two: upper_byte_enable or logic input
    logic        high_wr_n;   // high_write_pin: high_byte_write
    logic        strobe;      // strobe_pin: address_latch_strobe
  } mba_host_s;

  // Static bus configuration
  typedef struct packed {
    logic       mux;          // Multiplexed address/data bus
    mba_wmode_e wmode;        // Byte enable or split strobes
    logic       swap;         // Byte-swapped host type
    logic       use_strobe;   // Strobe wired on a non-multiplexed bus
  } mba_cfg_s;

endpackage
`default_nettype wire

// [hdl/mba_cell_access.sv]
// Host access to output cells, input cells and external selects
`default_nettype none

// What this block does
// RULE_01 - Host loads all 16 output cell flip-flops from its data bus.
// RULE_02 - Host load beats preset, clear and clock of the cell.
// RULE_03 - Load happens on the trailing edge of the write strobe.
// RULE_04 - Two write-mask registers, one per group of eight cells.
// RULE_05 - Both masks reset to zero so all cells accept loads.
// RULE_06 - A mask bit of one blocks the host load of that cell.
// RULE_07 - Mask bit n guards cell n of its group.
// RULE_08 - Cell pin enable is enable term ORed with direction bit.
// RULE_09 - Output pin without enable equation is driven from the first core clock after NRST rises.
// RULE_10 - Cell used as internal node frees its pin for other I/O.
// RULE_11 - 24 input cells: latch, register or pass-through each.
// RULE_12 - Input cell enable picks a product term or address strobe.
// RULE_13 - Input cells share control terms in groups of four.
// RULE_14 - Host can read all input cell outputs.
// RULE_15 - Strobe-clocked input cells capture high address bits for the array.
// RULE_16 - Eight external selects, one term each, selectable polarity.
// RULE_17 - Select pin enable is its enable term or direction bit.
// RULE_18 - Multiplexed bus: address latched on strobe, shown on latch outputs.
// RULE_19 - Address/data port driven only on selected read.
// RULE_20 - Non-multiplexed: data ports used and released when idle.
// RULE_21 - Upper byte enable and A0 decode word, odd or even byte.
// RULE_22 - Split low-active strobes decode word, odd or even byte.
// RULE_23 - Strobe optional on non-multiplexed bus unless latching wanted.
// RULE_24 - Unused third control pin serves as a logic input.
// RULE_25 - Dedicated clock updates cells on rising edge; preset/clear high.
// RULE_26 - Group A on D7-D0, group B on D15-D8; swap exchanges lanes.
module mba_cell_access
  import mba_pkg::*;
#(
  parameter logic [7:0] IO_BASE = 8'h00  // High address byte of io space
)(
  // Clock and reset
  input  wire logic                     CORE_CLK,
  input  wire logic                     NRST,
  // Host bus and configuration
  input  wire mba_pkg::mba_host_s       HOST,
  input  wire mba_pkg::mba_cfg_s        CFG,
  output var  logic [15:0]              AD_OUT,
  output var  logic                     AD_OE,
  output var  logic [15:0]              DATA_OUT,
  output var  logic                     DATA_OE,
  output var  logic [15:0]              LATCHED_ADDR,
  output var  logic                     CTRL2_TO_ARRAY,
  // Output cells
  input  wire logic [15:0]              CELL_D,
  input  wire logic [15:0]              CELL_PT_CLK,
  input  wire logic [15:0]              CELL_USE_CELL_CLOCK_IN,
  input  wire logic [15:0]              CELL_PRESET,
  input  wire logic [15:0]              CELL_CLEAR,
  input  wire logic                     CELL_CLOCK_IN,
  input  wire logic [15:0]              CELL_OE_PT,
  input  wire logic [15:0]              CELL_DIR,
  input  wire logic [15:0]              CELL_OE_UNDEF,
  input  wire logic [15:0]              CELL_IS_NODE,
  input  wire logic [15:0]              CELL_GPIO_OUT,
  output var  logic [15:0]              CELL_Q,
  output var  logic [15:0]              CELL_PIN_OUT,
  output var  logic [15:0]              CELL_PIN_OE,
  // Input cells
  input  wire logic [23:0]              IN_PINS,
  input  wire logic [47:0]              IN_MODE,
  input  wire logic [5:0]               IN_USE_STROBE,
  input  wire logic [5:0]               IN_PT,
  output var  logic [23:0]              IN_TO_ARRAY,
  // External selects
  input  wire logic [7:0]               SEL_PT,
  input  wire logic [7:0]               SEL_ACT_HIGH,
  input  wire logic [7:0]               SEL_OE_PT,
  input  wire logic [7:0]               SEL_DIR,
  output var  logic [7:0]               EXT_SEL_OUT,
  output var  logic [7:0]               EXT_SEL_OE
);
  import mba_pkg::*;

  // Exchange byte lanes when the host is byte-swapped
  function automatic logic [15:0] lane_swap(input logic [15:0] w, input logic s);
    lane_swap = s ? {w[7:0], w[15:8]} : w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address latch and decode

  logic [15:0] addr_lat_r;
  logic [15:0] addr_lat_nxt;
  logic [15:0] bus_addr;
  logic [15:0] bus_wdata;
  logic        hit;
  logic        hit_cell;
  logic        hit_mask;
  logic        hit_in_ab;
  logic        hit_in_c;

  // Transparent while the strobe is high, holds after it falls
  assign addr_lat_nxt = HOST.strobe ? HOST.ad : addr_lat_r;                  // RULE_18

  // Without a strobe on a plain bus the live address is used directly
  assign bus_addr  = (CFG.mux | CFG.use_strobe) ? addr_lat_r : HOST.ad;      // RULE_23
  assign bus_wdata = CFG.mux ? HOST.ad : HOST.data;                          // RULE_20

  // Word decode inside the io control space; bit 0 is the byte select
  assign hit       = (bus_addr[15:8] == IO_BASE);
  assign hit_cell  = hit & (bus_addr[7:1] == OFS_CELL[7:1]);
  assign hit_mask  = hit & (bus_addr[7:1] == OFS_MASK[7:1]);
  assign hit_in_ab = hit & (bus_addr[7:1] == OFS_IN_AB[7:1]);
  assign hit_in_c  = hit & (bus_addr[7:1] == OFS_IN_C[7:1]);

  ////////////////////////////////////////////////////////////////////////////
  // Write lane decode

  logic wr_lo;
  logic wr_hi;
  logic wr_act;

  // Byte enable style: ctrl_pin_two is upper_byte_enable, low active
  // Split style: ctrl_pin_zero is low_byte_write, high_write_pin the other
  assign wr_lo  = (CFG.wmode == WM_SPLIT) ? ~HOST.ctrl0_n                    // RULE_22
                                          : ~bus_addr[0];                    // RULE_21
  assign wr_hi  = (CFG.wmode == WM_SPLIT) ? ~HOST.high_wr_n                  // RULE_22
                                          : ~HOST.ctrl2;                     // RULE_21
  assign wr_act = (CFG.wmode == WM_SPLIT) ? (~HOST.ctrl0_n | ~HOST.high_wr_n)
                                          : ~HOST.ctrl0_n;

  ////////////////////////////////////////////////////////////////////////////
  // Write strobe tracking; data and lanes are held from the last active cycle

  logic        wr_act_r;
  logic [15:0] wdat_r;
  logic        wlo_r;
  logic        whi_r;
  logic        wcell_r;
  logic        wmask_r;
  logic        wr_end;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      wr_act_r <= 1'b0;
      wdat_r   <= WORD_RST;
      wlo_r    <= 1'b0;
      whi_r    <= 1'b0;
      wcell_r  <= 1'b0;
      wmask_r  <= 1'b0;
    end
    else
    begin
      wr_act_r <= wr_act;
      if (wr_act)
      begin
        wdat_r  <= lane_swap(bus_wdata, CFG.swap);                           // RULE_26
        wlo_r   <= wr_lo;
        whi_r   <= wr_hi;
        wcell_r <= hit_cell;
        wmask_r <= hit_mask;
      end
    end
  end

  // Trailing edge: strobe was active last cycle and is gone now
  assign wr_end = wr_act_r & ~wr_act;                                        // RULE_03

  ////////////////////////////////////////////////////////////////////////////
  // Write masks, group A on the low lane and group B on the high lane

  logic [7:0] mask_a_r;
  logic [7:0] mask_b_r;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      mask_a_r <= MASK_RST;                                                  // RULE_05
      mask_b_r <= MASK_RST;                                                  // RULE_05
    end
    else if (wr_end & wmask_r)
    begin
      if (wlo_r)
        mask_a_r <= wdat_r[7:0];                                             // RULE_04
      if (whi_r)
        mask_b_r <= wdat_r[15:8];                                            // RULE_04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output cell flip-flops

  logic [15:0] host_ld;
  logic [15:0] cell_clock_in_rise;
  logic [15:0] pt_rise;
  logic [15:0] cell_edge;
  logic [15:0] cell_q_r;
  logic [15:0] cell_nxt;
  logic        cell_clock_in_r;
  logic [15:0] pt_clk_r;

  // Per-cell load enable: lane written and mask bit n of the group clear
  assign host_ld = {16{wr_end & wcell_r}}                                    // RULE_01
                 & {{8{whi_r}}, {8{wlo_r}}}
                 & ~{mask_b_r, mask_a_r};                                    // RULE_06 RULE_07

  // Rising edges of the dedicated clock and of the term clocks.
  // Both are sampled on the core clock, so each must stay below half its rate.
  assign cell_clock_in_rise = {16{CELL_CLOCK_IN & ~cell_clock_in_r}};                        // RULE_25
  assign pt_rise    = CELL_PT_CLK & ~pt_clk_r;
  assign cell_edge  = (CELL_USE_CELL_CLOCK_IN & cell_clock_in_rise)
                    | (~CELL_USE_CELL_CLOCK_IN & pt_rise);

  // Host load first, then active-high preset and clear, then the clock
  always_comb
  begin
    for (int i = 0; i < NCELL; i++)
    begin
      if (host_ld[i])
        cell_nxt[i] = wdat_r[i];                                             // RULE_02
      else if (CELL_PRESET[i])
        cell_nxt[i] = 1'b1;                                                  // RULE_25
      else if (CELL_CLEAR[i])
        cell_nxt[i] = 1'b0;                                                  // RULE_25
      else if (cell_edge[i])
        cell_nxt[i] = CELL_D[i];
      else
        cell_nxt[i] = cell_q_r[i];
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cell_q_r <= WORD_RST;
      cell_clock_in_r  <= 1'b0;
      pt_clk_r <= WORD_RST;
    end
    else
    begin
      cell_q_r <= cell_nxt;
      cell_clock_in_r  <= CELL_CLOCK_IN;
      pt_clk_r <= CELL_PT_CLK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cell pins: a node keeps the cell inside and hands the pin to other I/O

  logic [15:0] pin_out_nxt;
  logic [15:0] pin_oe_nxt;

  assign pin_out_nxt = (CELL_IS_NODE & CELL_GPIO_OUT)
                     | (~CELL_IS_NODE & cell_nxt);                           // RULE_10
  assign pin_oe_nxt  = CELL_OE_PT | CELL_DIR                                 // RULE_08
                     | (CELL_OE_UNDEF & ~CELL_IS_NODE);                      // RULE_09

  ////////////////////////////////////////////////////////////////////////////
  // Input cells: group control of four, term or strobe as the enable

  logic [23:0] in_en;
  logic [23:0] in_en_r;
  logic [23:0] in_q_r;
  logic [23:0] in_q_nxt;
  logic [23:0] in_out;

  always_comb
  begin
    for (int i = 0; i < NIN; i++)
    begin
      in_en[i] = IN_USE_STROBE[i / INGRP] ? HOST.strobe                      // RULE_12 RULE_15
                                          : IN_PT[i / INGRP];                // RULE_13
    end
  end

  // Latch follows while enabled, register takes the rising edge
  always_comb
  begin
    for (int i = 0; i < NIN; i++)
    begin
      case (IN_MODE[2 * i +: 2])
        IM_LATCH: in_q_nxt[i] = in_en[i] ? IN_PINS[i] : in_q_r[i];            // RULE_11
        IM_REG:   in_q_nxt[i] = (in_en[i] & ~in_en_r[i]) ? IN_PINS[i]
                                                         : in_q_r[i];        // RULE_11
        default:  in_q_nxt[i] = IN_PINS[i];
      endcase
      in_out[i] = (IN_MODE[2 * i +: 2] == IM_PASS) ? IN_PINS[i] : in_q_r[i];  // RULE_11
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      in_q_r  <= {BYTE_RST, WORD_RST};
      in_en_r <= {BYTE_RST, WORD_RST};
    end
    else
    begin
      in_q_r  <= in_q_nxt;
      in_en_r <= in_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; pins are released whenever no selected read is under way

  logic [15:0] rd_word;
  logic        rd_on;

  assign rd_word = hit_cell  ? lane_swap(cell_q_r, CFG.swap)                 // RULE_26
                 : hit_mask  ? lane_swap({mask_b_r, mask_a_r}, CFG.swap)
                 : hit_in_ab ? lane_swap(in_out[15:0], CFG.swap)             // RULE_14
                 : hit_in_c  ? {BYTE_RST, in_out[23:16]}                     // RULE_14
                 : WORD_RST;
  // The enables are registered, so they trail the read strobe by one cycle;
  // the host must leave at least one wait state before it takes the data
  assign rd_on   = (hit_cell | hit_mask | hit_in_ab | hit_in_c) & ~HOST.ctrl1_n;

  ////////////////////////////////////////////////////////////////////////////
  // External selects

  logic [7:0] sel_nxt;
  logic [7:0] sel_oe_nxt;

  // One XNOR serves both polarities: an active-low select is the inverted term
  assign sel_nxt    = ~(SEL_PT ^ SEL_ACT_HIGH);                              // RULE_16
  assign sel_oe_nxt = SEL_OE_PT | SEL_DIR;                                   // RULE_17

  ////////////////////////////////////////////////////////////////////////////
  // Output registers; every top output leaves from a flip-flop

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      addr_lat_r     <= WORD_RST;
      AD_OUT         <= WORD_RST;
      AD_OE          <= 1'b0;
      DATA_OUT       <= WORD_RST;
      DATA_OE        <= 1'b0;
      LATCHED_ADDR   <= WORD_RST;
      CTRL2_TO_ARRAY <= 1'b0;
      CELL_Q         <= WORD_RST;
      CELL_PIN_OUT   <= WORD_RST;
      CELL_PIN_OE    <= WORD_RST;
      IN_TO_ARRAY    <= {BYTE_RST, WORD_RST};
      EXT_SEL_OUT    <= BYTE_RST;
      EXT_SEL_OE     <= BYTE_RST;
    end
    else
    begin
      addr_lat_r     <= addr_lat_nxt;
      AD_OUT         <= rd_word;
      AD_OE          <= rd_on & CFG.mux;                                     // RULE_19
      DATA_OUT       <= rd_word;
      DATA_OE        <= rd_on & ~CFG.mux;                                    // RULE_20
      LATCHED_ADDR   <= addr_lat_nxt;                                        // RULE_18
      CTRL2_TO_ARRAY <= (CFG.wmode == WM_SPLIT) ? HOST.ctrl2 : 1'b0;         // RULE_24
      CELL_Q         <= cell_nxt;
      CELL_PIN_OUT   <= pin_out_nxt;
      CELL_PIN_OE    <= pin_oe_nxt;
      IN_TO_ARRAY    <= in_out;                                              // RULE_15
      EXT_SEL_OUT    <= sel_nxt;                                             // RULE_16
      EXT_SEL_OE     <= sel_oe_nxt;
    end
  end

endmodule
`default_nettype wire

// [testbench/mba_cell_access_props.sv]
// Port checks for the host access block
`default_nettype none
module mba_cell_access_props
  import mba_pkg::*;
(
  // Clock, reset and host side
  input wire logic               CORE_CLK,
  input wire logic               NRST,
  input wire mba_pkg::mba_host_s HOST,
  input wire mba_pkg::mba_cfg_s  CFG,
  input wire logic               AD_OE,
  input wire logic               DATA_OE,
  input wire logic [15:0]        LATCHED_ADDR,
  input wire logic               CTRL2_TO_ARRAY,
  // Cells and selects
  input wire logic [15:0]        CELL_PT_CLK,
  input wire logic [15:0]        CELL_USE_CELL_CLOCK_IN,
  input wire logic [15:0]        CELL_PRESET,
  input wire logic [15:0]        CELL_CLEAR,
  input wire logic [15:0]        CELL_Q,
  input wire logic [7:0]         SEL_PT,
  input wire logic [7:0]         SEL_ACT_HIGH,
  input wire logic [7:0]         SEL_OE_PT,
  input wire logic [7:0]         SEL_DIR,
  input wire logic [7:0]         EXT_SEL_OUT,
  input wire logic [7:0]         EXT_SEL_OE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  ////////////////////////////////////////////////////////////////////////////
  // No internal cell activity, so only a host load may move the cells
  logic quiet;
  assign quiet = ~|{CELL_PT_CLK, CELL_USE_CELL_CLOCK_IN, CELL_PRESET, CELL_CLEAR};

  // Write strobe held low over two consecutive cycles
  sequence s_wr_low;
    quiet && !HOST.ctrl0_n;
  endsequence
  sequence s_wr_held;
    s_wr_low [*2];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Cells wait for the trailing edge; reads stay on the active bus
  property p_no_early_load; s_wr_held |-> $stable(CELL_Q); endproperty
  a_no_early_load: assert property (p_no_early_load)
    else $error("cells loaded before the write strobe ended");
  property p_ad_oe; AD_OE |-> CFG.mux && $past(HOST.ctrl1_n) == 1'b0; endproperty
  a_ad_oe: assert property (p_ad_oe)
    else $error("addr/data port driven outside a read");
  property p_data_oe; DATA_OE |-> !CFG.mux && $past(HOST.ctrl1_n) == 1'b0; endproperty
  a_data_oe: assert property (p_data_oe)
    else $error("data ports driven outside a read");
  property p_one_bus; AD_OE |-> !DATA_OE; endproperty
  a_one_bus: assert property (p_one_bus)
    else $error("both data paths driven");

  // Selects, freed control pin and the address latch
  property p_sel_oe; NRST |=> EXT_SEL_OE == ($past(SEL_OE_PT) | $past(SEL_DIR)); endproperty
  a_sel_oe: assert property (p_sel_oe)
    else $error("select enable is not term or direction");
  property p_sel_out; NRST |=> EXT_SEL_OUT == ~($past(SEL_PT) ^ $past(SEL_ACT_HIGH)); endproperty
  a_sel_out: assert property (p_sel_out)
    else $error("select polarity wrong");
  property p_ctrl2;
    NRST |=> CTRL2_TO_ARRAY == ($past(HOST.ctrl2) && $past(CFG.wmode) == WM_SPLIT);
  endproperty
  a_ctrl2: assert property (p_ctrl2)
    else $error("free control pin not passed to array");
  property p_latch; CFG.mux && HOST.strobe |=> LATCHED_ADDR == $past(HOST.ad); endproperty
  a_latch: assert property (p_latch)
    else $error("address not latched on strobe");
  property p_latch_hold; CFG.mux && !HOST.strobe |=> $stable(LATCHED_ADDR); endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched address moved without strobe");
endmodule

bind mba_cell_access mba_cell_access_props i_props (
  .CORE_CLK, .NRST, .HOST, .CFG, .AD_OE, .DATA_OE, .LATCHED_ADDR, .CTRL2_TO_ARRAY,
  .CELL_PT_CLK, .CELL_USE_CELL_CLOCK_IN, .CELL_PRESET, .CELL_CLEAR, .CELL_Q, .SEL_PT,
  .SEL_ACT_HIGH, .SEL_OE_PT, .SEL_DIR, .EXT_SEL_OUT, .EXT_SEL_OE
);
`default_nettype wire

// [testbench/mba_host_model.sv]
// Host microcontroller model for the shared parallel bus
`default_nettype none
module mba_host_model
  import mba_pkg::*;
(
  // Clock and configuration
  input  wire logic               CORE_CLK,
  input  wire mba_pkg::mba_cfg_s  CFG,
  // Device side of the bus
  input  wire logic [15:0]        AD_OUT,
  input  wire logic               AD_OE,
  input  wire logic [15:0]        DATA_OUT,
  input  wire logic               DATA_OE,
  output var  mba_pkg::mba_host_s HOST
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ad_drv = 16'h0000;
  logic [15:0] dat_drv = 16'h0000;
  logic        stb = 1'b0;
  logic        rd_n = 1'b1;
  logic        ube_n = 1'b1;
  logic        hw_n = 1'b1;
  logic        lw_n = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Wire levels: the device wins where it drives, the host elsewhere
  assign HOST = '{ad: AD_OE ? AD_OUT : ad_drv, data: DATA_OE ? DATA_OUT : dat_drv,
                  ctrl0_n: lw_n, ctrl1_n: rd_n, ctrl2: ube_n, high_wr_n: hw_n,
                  strobe: stb};

  // Write: address phase, strobes low three cycles, then lines let go
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [2:0] lanes_n);
    @(posedge CORE_CLK);
    stb <= 1'b1;
    ad_drv <= a;
    dat_drv <= d;
    ube_n <= lanes_n[2];
    @(posedge CORE_CLK);
    stb <= 1'b0;
    if (CFG.mux)
      ad_drv <= d;
    {hw_n, lw_n} <= lanes_n[1:0];
    repeat (3) @(posedge CORE_CLK);
    {hw_n, lw_n} <= 2'h3;
    @(posedge CORE_CLK);
    ad_drv <= ~ad_drv;
    dat_drv <= ~d;
    // The cells load on the edge above; return once they show
    @(posedge CORE_CLK);
  endtask

  // Read: address phase, then read strobe while watching the enables
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic oe);
    oe = 1'b0;
    d = 16'h0000;
    @(posedge CORE_CLK);
    stb <= 1'b1;
    ad_drv <= a;
    @(posedge CORE_CLK);
    stb <= 1'b0;
    if (CFG.mux || CFG.use_strobe)
      ad_drv <= ~a;
    rd_n <= 1'b0;
    repeat (4)
    begin
      @(posedge CORE_CLK);
      if (!oe && (AD_OE === 1'b1 || DATA_OE === 1'b1))
      begin
        oe = 1'b1;
        d = CFG.mux ? AD_OUT : DATA_OUT;
      end
    end
    rd_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the host access block
`default_nettype none
module testbench
  import mba_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  mba_cfg_s cfg;
  mba_host_s host;
  logic [15:0] ad_out, data_out, l_addr, cq, p_out, p_oe, rdat;
  logic [15:0] c_d, pt_clk, u_cell_clock_in, preset, clear, oe_pt, dir, oe_undef, is_node, gpio;
  logic [23:0] in_pins, in_arr;
  logic [47:0] in_mode;
  logic [5:0]  in_ustb, in_pt;
  logic [7:0]  s_pt, s_hi, s_oe_pt, s_dir, s_out, s_oe;
  logic        ad_oe, data_oe, c2_arr, clk_in, rok;
  int          error_cnt = 0;
  int          checks = 0;
  int          cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  mba_cell_access i_mba_cell_access (.CORE_CLK(core_clk), .NRST(nrst), .HOST(host),
    .CFG(cfg), .AD_OUT(ad_out), .AD_OE(ad_oe), .DATA_OUT(data_out), .DATA_OE(data_oe),
    .LATCHED_ADDR(l_addr), .CTRL2_TO_ARRAY(c2_arr), .CELL_D(c_d), .CELL_PT_CLK(pt_clk),
    .CELL_USE_CELL_CLOCK_IN(u_cell_clock_in), .CELL_PRESET(preset), .CELL_CLEAR(clear),
    .CELL_CLOCK_IN(clk_in), .CELL_OE_PT(oe_pt), .CELL_DIR(dir), .CELL_OE_UNDEF(oe_undef),
    .CELL_IS_NODE(is_node), .CELL_GPIO_OUT(gpio), .CELL_Q(cq), .CELL_PIN_OUT(p_out),
    .CELL_PIN_OE(p_oe), .IN_PINS(in_pins), .IN_MODE(in_mode), .IN_USE_STROBE(in_ustb),
    .IN_PT(in_pt), .IN_TO_ARRAY(in_arr), .SEL_PT(s_pt), .SEL_ACT_HIGH(s_hi),
    .SEL_OE_PT(s_oe_pt), .SEL_DIR(s_dir), .EXT_SEL_OUT(s_out), .EXT_SEL_OE(s_oe));
  mba_host_model i_mba_host_model (.CORE_CLK(core_clk), .CFG(cfg), .AD_OUT(ad_out),
    .AD_OE(ad_oe), .DATA_OUT(data_out), .DATA_OE(data_oe), .HOST(host));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a hang limit well above the expected run length
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register read with data compare; a missing answer reads as a mismatch
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
    i_mba_host_model.rd(a, rdat, rok);
    chk(what, {8'h00, 1'b1, exp[15:1]}, {8'h00, rok, rdat[15:1]});
    chk(what, {23'h00_0000, exp[0]}, {23'h00_0000, rdat[0]});
  endtask

  // Static levels are registered; give them a few edges to land
  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {c_d, pt_clk, u_cell_clock_in, preset, clear, oe_pt, dir, oe_undef, is_node, gpio} = '0;
    {clk_in, in_mode, in_ustb, in_pt, s_pt, s_hi, s_oe_pt, s_dir} = '0;
    in_pins = 24'h5A_C396;
    cfg = '{mux: 1'b1, wmode: WM_BYTE_EN, swap: 1'b0, use_strobe: 1'b0};
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    s_pt <= 8'hA5;
    s_hi <= 8'h0F;
    s_oe_pt <= 8'h30;
    s_dir <= 8'h03;
    settle();
    chk("cells after reset", 24'h00_0000, {8'h00, cq});
    rd_chk("masks after reset", 16'h0022, 16'h0000);
    i_mba_host_model.wr(16'h0020, 16'h1234, 3'h2);
    chk("word load", 24'h00_1234, {8'h00, cq});
    rd_chk("cell readback", 16'h0020, 16'h1234);
    i_mba_host_model.wr(16'h0022, 16'h0F0F, 3'h2);
    rd_chk("mask readback", 16'h0022, 16'h0F0F);
    i_mba_host_model.wr(16'h0020, 16'hFFFF, 3'h2);
    chk("masked load", 24'h00_F2F4, {8'h00, cq});
    i_mba_host_model.wr(16'h0022, 16'h0000, 3'h2);
    i_mba_host_model.wr(16'h0021, 16'hAB00, 3'h2);
    chk("odd byte", 24'h00_ABF4, {8'h00, cq});
    i_mba_host_model.wr(16'h0020, 16'h00CD, 3'h6);
    chk("even byte", 24'h00_ABCD, {8'h00, cq});
    i_mba_host_model.rd(16'h0040, rdat, rok);
    chk("unmapped read", 24'h00_0000, {23'h00_0000, rok});
    rd_chk("input cells", 16'h0018, 16'hC396);
    chk("pass input", 24'h5A_C396, in_arr);
    in_mode <= 48'h0000_0000_00AA;
    in_ustb <= 6'h01;
    settle();
    in_pins <= 24'h5A_C39F;
    settle();
    chk("registered input held", 24'h5A_C396, in_arr);
    rd_chk("registered input", 16'h0018, 16'hC39F);
    chk("strobe capture", 24'h5A_C39F, in_arr);
    @(posedge core_clk);
    cfg.wmode <= WM_SPLIT;
    i_mba_host_model.wr(16'h0020, 16'h1100, 3'h5);
    chk("split high", 24'h00_11CD, {8'h00, cq});
    i_mba_host_model.wr(16'h0020, 16'h0022, 3'h6);
    chk("split low", 24'h00_1122, {8'h00, cq});
    i_mba_host_model.wr(16'h0020, 16'h3344, 3'h4);
    chk("split word", 24'h00_3344, {8'h00, cq});
    @(posedge core_clk);
    cfg <= '{mux: 1'b1, wmode: WM_BYTE_EN, swap: 1'b1, use_strobe: 1'b0};
    i_mba_host_model.wr(16'h0020, 16'h1234, 3'h2);
    chk("swapped load", 24'h00_3412, {8'h00, cq});
    rd_chk("swapped read", 16'h0020, 16'h1234);
    @(posedge core_clk);
    cfg <= '{mux: 1'b0, wmode: WM_BYTE_EN, swap: 1'b0, use_strobe: 1'b0};
    i_mba_host_model.wr(16'h0020, 16'h5566, 3'h2);
    chk("flat bus load", 24'h00_5566, {8'h00, cq});
    rd_chk("flat bus read", 16'h0020, 16'h5566);
    cfg.use_strobe <= 1'b1;
    rd_chk("latched flat read", 16'h0020, 16'h5566);
    @(posedge core_clk);
    oe_pt <= 16'h00F0;
    dir <= 16'h0F00;
    settle();
    chk("pin enable", 24'h00_0FF0, {8'h00, p_oe});
    oe_undef <= 16'hF000;
    u_cell_clock_in <= 16'hFFFF;
    c_d <= 16'h00FF;
    settle();
    chk("no enable term", 24'h00_FFF0, {8'h00, p_oe});
    clk_in <= 1'b1;
    settle();
    clk_in <= 1'b0;
    chk("clock input", 24'h00_00FF, {8'h00, cq});
    clear <= 16'h000F;
    is_node <= 16'h0001;
    gpio <= 16'h0001;
    settle();
    chk("clear", 24'h00_00F0, {8'h00, cq});
    chk("node pin", 24'h00_0001, {23'h00_0000, p_out[0]});
    tally_and_finish();
  end
endmodule
`default_nettype wire
